// ### verilog/cfg_caps_pkg.sv
// Package with offsets, reset values, states and helpers of the switch port config bank.
package cfg_caps_pkg;

  // ****************************************************************
  // Register byte offsets and dword indices
  // ****************************************************************
  localparam logic [11:0] SUBSYSTEM_CODE_CAP_OFF = 12'h0f0;
  localparam logic [11:0] SUBSYS_OFF = 12'h0f4;
  localparam logic [11:0] ADDR_OFF = 12'h0f8;
  localparam logic [11:0] DATA_OFF = 12'h0fc;
  localparam logic [11:0] AER_CAP_OFF = 12'h100;
  localparam logic [11:0] UE_STATUS_OFF = 12'h104;

  localparam logic [9:0] SUBSYSTEM_CODE_CAP_IDX = SUBSYSTEM_CODE_CAP_OFF[11:2];
  localparam logic [9:0] SUBSYS_IDX = SUBSYS_OFF[11:2];
  localparam logic [9:0] ADDR_IDX = ADDR_OFF[11:2];
  localparam logic [9:0] DATA_IDX = DATA_OFF[11:2];
  localparam logic [9:0] AER_CAP_IDX = AER_CAP_OFF[11:2];
  localparam logic [9:0] UE_STATUS_IDX = UE_STATUS_OFF[11:2];
  localparam int CFG_WORDS = 1024;

  // ****************************************************************
  // Field values, reset values and masks
  // ****************************************************************
  localparam logic [7:0] SUBSYSTEM_CODE_CAP_ID = 8'h0d;
  localparam logic [7:0] SUBSYSTEM_CODE_NEXT_RST = 8'h00;
  localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_WMASK = 32'h0000_0ffc;
  localparam logic [15:0] AER_CAP_ID = 16'h0001;
  localparam logic [3:0] AER_CAP_VER = 4'h1;
  localparam logic [11:0] AER_NEXT_RST = 12'h200;

  localparam int UE_DLP_BIT = 4;
  localparam int UE_SDOWN_BIT = 5;
  localparam int UE_POISON_BIT = 12;
  localparam int UE_FCP_BIT = 13;
  localparam int UE_CPL_TO_BIT = 14;
  localparam int UE_COMPLETER_ABORT_FLAG_BIT = 15;
  localparam int UE_UCPL_BIT = 16;
  localparam int UE_RECEIVER_OVERFLOW_FLAG_BIT = 17;
  localparam int UE_MALF_BIT = 18;
  localparam int UE_ECRC_BIT = 19;
  localparam int UE_UR_BIT = 20;
  localparam logic [31:0] UE_LIVE_MASK = 32'h001f_3030;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ANSWER = 2'b10
  } cfg_state_t;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    return (wd & be_mask(be)) | (old & ~be_mask(be));
  endfunction

  function automatic logic is_local(input logic [9:0] idx);
    return (idx >= SUBSYSTEM_CODE_CAP_IDX) && (idx <= UE_STATUS_IDX);
  endfunction

  function automatic logic [31:0] flag_at(input int pos, input logic v);
    return {31'h0, v} << pos;
  endfunction

endpackage

// ### verilog/cfg_word_mem.sv
// Byte-writable backing store for configuration dwords outside the local registers.
`timescale 1ns/1ps
module cfg_word_mem
  import cfg_caps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [3:0] be_i,
  input wire logic [9:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);

  logic [31:0] mem [CFG_WORDS];

  // The array has no reset, so words read back undefined until written.
  always_ff @(posedge clk_i)
  begin
    if (we_i)
      mem[addr_i] <= merge_be(mem[addr_i], wdata_i, be_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0000_0000;
    else
      rdata_o <= mem[addr_i];
  end

endmodule

// ### verilog/aer_sticky_status.sv
// Sticky write-one-to-clear status bits; only the fundamental reset clears them.
`timescale 1ns/1ps
module aer_sticky_status
  import cfg_caps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] set_i,
  input wire logic [31:0] clr_i,
  output logic [31:0] status_o
);

  wire [31:0] next_status;

  for (genvar i = 0; i < 32; i++)
  begin : g_bit
    if (UE_LIVE_MASK[i])
    begin : g_live
      // A set in the same cycle as a clear wins, so no event is lost.
      assign next_status[i] = set_i[i] | (status_o[i] & ~clr_i[i]);
    end
    else
    begin : g_zero
      assign next_status[i] = 1'b0;
    end
  end

  // One register for the whole word, so the output has a single driver.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      status_o <= 32'h0000_0000;
    else
      status_o <= next_status;
  end

endmodule

// ### verilog/switch_port_config_caps_aer_status.sv
// Switch port config bank: subsystem id capability, indirect window and AER status.
`timescale 1ns/1ps
module switch_port_config_caps_aer_status
  import cfg_caps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hot_rst_i,
  input wire logic cfg_req_i,
  input wire logic cfg_we_i,
  input wire logic cfg_smbus_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic cfg_lock_i,
  input wire logic sd_report_capable_i,
  input wire logic link_protocol_err_i,
  input wire logic surprise_down_err_i,
  input wire logic poisoned_tlp_err_i,
  input wire logic flow_control_err_i,
  input wire logic unexpected_cpl_err_i,
  input wire logic receiver_overflow_err_i,
  input wire logic malformed_tlp_err_i,
  input wire logic ecrc_err_i,
  input wire logic unsupported_req_err_i,
  output logic cfg_ack_o,
  output logic [31:0] cfg_rdata_o,
  output logic [31:0] err_status_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  cfg_state_t state;
  cfg_state_t next_state;
  logic [7:0] subsystem_code_next_ptr;
  logic [31:0] subsys;
  logic [31:0] ind_addr;
  logic [11:0] aer_next_ptr;
  logic [9:0] p_idx;
  logic p_we;
  logic p_null;
  logic [31:0] mem_rdata;
  logic [31:0] ue_status;
  logic [31:0] ue_set;
  logic [31:0] ue_clr;

  // Read value of a local register; the register values come in as
  // arguments so that a continuous assignment sees every change.
  function automatic logic [31:0] local_word(input logic [9:0] idx,
                                             input logic [7:0] nptr,
                                             input logic [31:0] ss,
                                             input logic [31:0] ia,
                                             input logic [11:0] aptr,
                                             input logic [31:0] st);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == SUBSYSTEM_CODE_CAP_IDX)
      w = {16'h0000, nptr, SUBSYSTEM_CODE_CAP_ID};
    else if (idx == SUBSYS_IDX)
      w = ss;
    else if (idx == ADDR_IDX)
      w = ia & ADDR_WMASK;
    else if (idx == AER_CAP_IDX)
      w = {aptr, AER_CAP_VER, AER_CAP_ID};
    else if (idx == UE_STATUS_IDX)
      w = st;
    return w;
  endfunction

  // ****************************************************************
  // Request decode
  // ****************************************************************
  wire take;
  wire [9:0] dir_idx;
  wire [9:0] ind_idx;
  wire via_data;
  wire tgt_null;
  wire [9:0] tgt_idx;
  wire wr_go;
  wire lock_ok;
  wire tgt_local;
  wire mem_we;
  wire [31:0] tgt_word;
  wire [31:0] wr_merged;
  wire [31:0] ans_word;
  wire wr_subsystem_code_cap;
  wire wr_subsys;
  wire wr_addr;
  wire wr_aer_cap;
  wire wr_status;

  // Only one request is in flight; requests during the answer cycle are
  // not taken, which keeps reads ordered behind earlier writes.
  assign take = cfg_req_i && (state == ST_IDLE);
  assign dir_idx = cfg_addr_i[11:2];
  assign ind_idx = ind_addr[11:2];
  assign via_data = dir_idx == DATA_IDX;
  assign tgt_null = via_data && (cfg_smbus_i || ind_idx == DATA_IDX);
  assign tgt_idx = via_data ? ind_idx : dir_idx;
  assign wr_go = take && cfg_we_i && !tgt_null;
  assign lock_ok = !cfg_lock_i || cfg_smbus_i;
  assign tgt_local = is_local(tgt_idx);
  assign mem_we = wr_go && !tgt_local;

  assign tgt_word = local_word(tgt_idx, subsystem_code_next_ptr, subsys, ind_addr, aer_next_ptr,
                               ue_status);
  assign wr_merged = merge_be(tgt_word, cfg_wdata_i, cfg_be_i);

  assign wr_subsystem_code_cap = wr_go && lock_ok && tgt_idx == SUBSYSTEM_CODE_CAP_IDX;
  assign wr_subsys = wr_go && lock_ok && tgt_idx == SUBSYS_IDX;
  assign wr_addr = wr_go && tgt_idx == ADDR_IDX;
  assign wr_aer_cap = wr_go && lock_ok && tgt_idx == AER_CAP_IDX;
  assign wr_status = wr_go && tgt_idx == UE_STATUS_IDX;

  // ****************************************************************
  // Local registers
  // ****************************************************************
  // Hot or link reset returns these to their reset values; the sticky
  // status bits are kept in their own module and ignore it.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      subsystem_code_next_ptr <= SUBSYSTEM_CODE_NEXT_RST;
      subsys <= SUBSYS_RST;
      ind_addr <= ADDR_RST;
      aer_next_ptr <= AER_NEXT_RST;
    end
    else if (hot_rst_i)
    begin
      subsystem_code_next_ptr <= SUBSYSTEM_CODE_NEXT_RST;
      subsys <= SUBSYS_RST;
      ind_addr <= ADDR_RST;
      aer_next_ptr <= AER_NEXT_RST;
    end
    else
    begin
      if (wr_subsystem_code_cap)
        subsystem_code_next_ptr <= wr_merged[15:8];
      if (wr_subsys)
        subsys[15:0] <= wr_merged[15:0];
      if (wr_subsys)
        subsys[31:16] <= wr_merged[31:16];
      if (wr_addr)
        ind_addr <= wr_merged & ADDR_WMASK;
      if (wr_aer_cap)
        aer_next_ptr <= wr_merged[31:20];
    end
  end

  // ****************************************************************
  // Uncorrectable error status
  // ****************************************************************
  assign ue_set = flag_at(UE_DLP_BIT, link_protocol_err_i)
                | flag_at(UE_SDOWN_BIT, surprise_down_err_i && sd_report_capable_i)
                | flag_at(UE_POISON_BIT, poisoned_tlp_err_i)
                | flag_at(UE_FCP_BIT, flow_control_err_i)
                | flag_at(UE_UCPL_BIT, unexpected_cpl_err_i)
                | flag_at(UE_RECEIVER_OVERFLOW_FLAG_BIT, receiver_overflow_err_i)
                | flag_at(UE_MALF_BIT, malformed_tlp_err_i)
                | flag_at(UE_ECRC_BIT, ecrc_err_i)
                | flag_at(UE_UR_BIT, unsupported_req_err_i);

  // Bits 14 and 15 have no source and stay zero in the status module.
  assign ue_clr = (wr_status ? (cfg_wdata_i & be_mask(cfg_be_i)) : 32'h0000_0000)
                | flag_at(UE_SDOWN_BIT, !sd_report_capable_i);

  aer_sticky_status u_status (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ue_set),
    .clr_i(ue_clr),
    .status_o(ue_status)
  );

  assign err_status_o = ue_status;

  // ****************************************************************
  // Backing store for all other configuration dwords
  // ****************************************************************
  cfg_word_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .be_i(cfg_be_i),
    .addr_i(tgt_idx),
    .wdata_i(cfg_wdata_i),
    .rdata_o(mem_rdata)
  );

  // ****************************************************************
  // Answer sequencing
  // ****************************************************************
  assign ans_word = p_null ? 32'h0000_0000 :
                    is_local(p_idx) ? local_word(p_idx, subsystem_code_next_ptr, subsys, ind_addr,
                                                 aer_next_ptr, ue_status) :
                    mem_rdata;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (take)
          next_state = ST_ANSWER;
      ST_ANSWER:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      p_idx <= 10'h000;
      p_we <= 1'b0;
      p_null <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (take)
      begin
        p_idx <= tgt_idx;
        p_we <= cfg_we_i;
        p_null <= tgt_null;
      end
    end
  end

  // Write answers carry zero data so a stale read value never leaks out.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_ack_o <= 1'b0;
      cfg_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      cfg_ack_o <= state == ST_ANSWER;
      if (state == ST_ANSWER)
        cfg_rdata_o <= p_we ? 32'h0000_0000 : ans_word;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence rd_take(logic [9:0] idx);
    take && !cfg_we_i && !tgt_null && tgt_idx == idx;
  endsequence

  sequence answer_seq;
    !cfg_ack_o ##1 cfg_ack_o;
  endsequence

  ack_timing_a: assert property (take |=> answer_seq)
    else $error("answer not given two edges after the request");

  cap_id_read_a: assert property (rd_take(SUBSYSTEM_CODE_CAP_IDX) |-> ##2
      cfg_rdata_o[7:0] == SUBSYSTEM_CODE_CAP_ID && cfg_rdata_o[31:16] == 16'h0000)
    else $error("subsystem capability header reads wrong");

  aer_id_read_a: assert property (rd_take(AER_CAP_IDX) |-> ##2
      cfg_rdata_o[19:0] == {AER_CAP_VER, AER_CAP_ID})
    else $error("error reporting header reads wrong");

  addr_rsvd_a: assert property (rd_take(ADDR_IDX) |-> ##2
      cfg_rdata_o[1:0] == 2'h0 && cfg_rdata_o[31:12] == 20'h00000)
    else $error("indirect address reserved bits not zero");

  self_select_a: assert property (take && !cfg_we_i && via_data && !cfg_smbus_i &&
      ind_idx == DATA_IDX |-> ##2 cfg_ack_o && cfg_rdata_o == 32'h0000_0000)
    else $error("self-selected data register did not read zero");

  smbus_data_a: assert property (take && via_data && cfg_smbus_i |-> ##2
      cfg_ack_o && cfg_rdata_o == 32'h0000_0000)
    else $error("management port data access did not read zero");

  smbus_nowrite_a: assert property (take && cfg_we_i && via_data && cfg_smbus_i &&
      !hot_rst_i |=> $stable(subsys) && $stable(ind_addr))
    else $error("management port data write had an effect");

  subsys_write_a: assert property (wr_subsys && !hot_rst_i |=>
      subsys == merge_be($past(subsys), $past(cfg_wdata_i), $past(cfg_be_i)))
    else $error("identity write ignored byte enables");

  ind_read_a: assert property (rd_take(SUBSYS_IDX) and via_data |-> ##2
      cfg_rdata_o == $past(subsys))
    else $error("indirect read returned wrong value");

  dlp_set_a: assert property (link_protocol_err_i |=> err_status_o[UE_DLP_BIT])
    else $error("link protocol error not logged");

  sd_gate_a: assert property (!sd_report_capable_i |=> !err_status_o[UE_SDOWN_BIT])
    else $error("surprise down bit set while not capable");

  hard_zero_a: assert property (rd_take(UE_STATUS_IDX) |-> ##2
      cfg_rdata_o[UE_COMPLETER_ABORT_FLAG_BIT:UE_CPL_TO_BIT] == 2'h0)
    else $error("hardwired status bits read nonzero");

  w1c_clear_a: assert property (wr_status && cfg_be_i[2] && cfg_wdata_i[UE_UR_BIT] &&
      !unsupported_req_err_i |=> !err_status_o[UE_UR_BIT])
    else $error("write one did not clear status");

  set_wins_a: assert property (wr_status && cfg_be_i[2] && cfg_wdata_i[UE_UR_BIT] &&
      unsupported_req_err_i |=> err_status_o[UE_UR_BIT])
    else $error("event lost against a clear");

  sticky_hot_a: assert property (hot_rst_i && !wr_status && err_status_o[UE_ECRC_BIT] |=>
      err_status_o[UE_ECRC_BIT])
    else $error("sticky bit lost on hot reset");

endmodule

// ### sim/cfg_requester_model.sv
// Behavioural configuration requester that drives the config port of the switch port bank.
`timescale 1ns/1ps
module cfg_requester_model
(
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] rdata_i,
  output logic req_o,
  output logic we_o,
  output logic smbus_o,
  output logic [11:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  initial
  begin
    req_o = 1'b0;
    we_o = 1'b0;
    smbus_o = 1'b0;
    addr_o = 12'h000;
    be_o = 4'h0;
    wdata_o = 32'h0000_0000;
  end

  // ****************************************************************
  // One request, one answer
  // ****************************************************************
  // The request is dropped right after its take edge, because a request still high on the edge
  // after the answer edge would be taken a second time. Returns unknown data if no answer comes.
  task automatic access(input logic we, input logic smb, input logic [11:0] a,
                        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    req_o <= 1'b1;
    we_o <= we;
    smbus_o <= smb;
    addr_o <= a;
    be_o <= be;
    wdata_o <= wd;
    @(posedge clk_i);
    // Address, byte enables and write data flip, so a late sample of them cannot match by luck.
    req_o <= 1'b0;
    addr_o <= ~a;
    be_o <= ~be;
    wdata_o <= ~wd;
    rd = 32'hxxxx_xxxx;
    n = 0;
    while (n < 8)
    begin
      @(posedge clk_i);
      #1;
      if (ack_i === 1'b1)
      begin
        rd = rdata_i;
        n = 8;
      end
      else
      begin
        n++;
      end
    end
  endtask
endmodule

// ### sim/switch_port_config_caps_aer_status_tb.sv
// Self-checking testbench of the switch port config bank.
`timescale 1ns/1ps
module switch_port_config_caps_aer_status_tb;
  import cfg_caps_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hot_rst = 1'b0;
  logic lock = 1'b0;
  logic sd_cap = 1'b1;
  logic [8:0] ev = 9'h000;
  logic req;
  logic we;
  logic smb;
  logic ack;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] status;
  logic [31:0] exp_v;
  int fails = 0;
  int cmp_count = 0;
  int bit_pos [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

  always #12.5 clk = ~clk;

  cfg_requester_model req_m (.clk_i(clk), .ack_i(ack), .rdata_i(rdata), .req_o(req),
    .we_o(we), .smbus_o(smb), .addr_o(addr), .be_o(be), .wdata_o(wdata));

  switch_port_config_caps_aer_status dut (.clk_i(clk), .rst_i(rst), .hot_rst_i(hot_rst),
    .cfg_req_i(req), .cfg_we_i(we), .cfg_smbus_i(smb), .cfg_addr_i(addr), .cfg_be_i(be),
    .cfg_wdata_i(wdata), .cfg_lock_i(lock), .sd_report_capable_i(sd_cap),
    .link_protocol_err_i(ev[0]), .surprise_down_err_i(ev[1]), .poisoned_tlp_err_i(ev[2]),
    .flow_control_err_i(ev[3]), .unexpected_cpl_err_i(ev[4]),
    .receiver_overflow_err_i(ev[5]), .malformed_tlp_err_i(ev[6]), .ecrc_err_i(ev[7]),
    .unsupported_req_err_i(ev[8]), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
    .err_status_o(status));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [3:0] b = 4'hf,
                    input logic s = 1'b0);
    logic [31:0] v;
    req_m.access(1'b0, s, a, b, 32'h0000_0000, v);
    check($sformatf("read of %h", a), exp, v);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b = 4'hf,
                    input logic s = 1'b0);
    logic [31:0] v;
    req_m.access(1'b1, s, a, b, d, v);
    check($sformatf("write answer of %h", a), 32'h0000_0000, v);
  endtask

  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
  endtask

  task automatic results();
    if (fails == 0 && cmp_count > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A full run needs well under a thousand cycles.
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    results();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(SUBSYSTEM_CODE_CAP_OFF, 32'h0000_000d);
    rd(SUBSYS_OFF, 32'h0000_0000);
    rd(ADDR_OFF, 32'h0000_0000);
    rd(AER_CAP_OFF, 32'h2001_0001);
    rd(UE_STATUS_OFF, 32'h0000_0000);
    wr(SUBSYSTEM_CODE_CAP_OFF, 32'hffff_ffff);
    rd(SUBSYSTEM_CODE_CAP_OFF, 32'h0000_ff0d);
    wr(AER_CAP_OFF, 32'hffff_ffff);
    rd(AER_CAP_OFF, 32'hfff1_0001);
    wr(SUBSYS_OFF, 32'h1234_5678);
    rd(SUBSYS_OFF, 32'h1234_5678);
    @(posedge clk);
    lock <= 1'b1;
    wr(SUBSYS_OFF, 32'h0000_0000);
    rd(SUBSYS_OFF, 32'h1234_5678);
    wr(SUBSYSTEM_CODE_CAP_OFF, 32'h0000_0000);
    rd(SUBSYSTEM_CODE_CAP_OFF, 32'h0000_ff0d);
    wr(SUBSYS_OFF, 32'habcd_ef01, 4'hf, 1'b1);
    wr(SUBSYS_OFF, 32'h5555_0000, 4'hc, 1'b1);
    rd(SUBSYS_OFF, 32'h5555_ef01);
    wr(ADDR_OFF, 32'hffff_ffff);
    rd(ADDR_OFF, 32'h0000_0ffc);
    wr(ADDR_OFF, 32'h0000_0040);
    wr(DATA_OFF, 32'ha5a5_a5a5);
    rd(12'h040, 32'ha5a5_a5a5);
    wr(DATA_OFF, 32'h1122_3344, 4'h3);
    rd(12'h040, 32'ha5a5_3344);
    wr(12'h040, 32'hdead_beef);
    rd(DATA_OFF, 32'hdead_beef);
    rd(DATA_OFF, 32'h0000_0000, 4'hf, 1'b1);
    wr(DATA_OFF, 32'h0000_0000, 4'hf, 1'b1);
    rd(12'h040, 32'hdead_beef);
    wr(ADDR_OFF, 32'h0000_00f4);
    rd(DATA_OFF, 32'h5555_ef01);
    wr(ADDR_OFF, 32'h0000_0100);
    rd(DATA_OFF, 32'hfff1_0001);
    wr(ADDR_OFF, 32'h0000_00fc);
    rd(DATA_OFF, 32'h0000_0000);
    wr(DATA_OFF, 32'h1357_9bdf);
    rd(ADDR_OFF, 32'h0000_00fc);
    rd(DATA_OFF, 32'h0000_0000);
    foreach (bit_pos[i])
    begin
      exp_v = 32'h0000_0001 << bit_pos[i];
      pulse(9'h001 << i);
      rd(UE_STATUS_OFF, exp_v);
      check("status port", exp_v, status);
      wr(UE_STATUS_OFF, ~exp_v);
      rd(UE_STATUS_OFF, exp_v);
      wr(UE_STATUS_OFF, exp_v);
      rd(UE_STATUS_OFF, 32'h0000_0000);
    end
    // The event lands on the same edge that takes the clearing write.
    fork
      pulse(9'h100);
      wr(UE_STATUS_OFF, 32'h0010_0000);
    join
    rd(UE_STATUS_OFF, 32'h0010_0000);
    pulse(9'h1ff);
    rd(UE_STATUS_OFF, 32'h001f_3030);
    @(posedge clk);
    hot_rst <= 1'b1;
    @(posedge clk);
    hot_rst <= 1'b0;
    rd(UE_STATUS_OFF, 32'h001f_3030);
    rd(SUBSYS_OFF, 32'h0000_0000);
    rd(SUBSYSTEM_CODE_CAP_OFF, 32'h0000_000d);
    rd(AER_CAP_OFF, 32'h2001_0001);
    @(posedge clk);
    sd_cap <= 1'b0;
    rd(UE_STATUS_OFF, 32'h001f_3010);
    pulse(9'h002);
    rd(UE_STATUS_OFF, 32'h001f_3010);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(UE_STATUS_OFF, 32'h0000_0000);
    check("status port after reset", 32'h0000_0000, status);
    results();
  end
endmodule
